// File: hw/uad_params.svh
`ifndef UAD_PARAMS_SVH
`define UAD_PARAMS_SVH
`define UAD_GPIO_W       16
`define UAD_SENSE_LINE   2
`define UAD_DETACH_LINE  3
`define UAD_WAKE_LINE    4
`define UAD_PULLUP_LINE  5
`define UAD_SETTLE_NS    1000
`define UAD_CLK_NS       8
`define UAD_SETTLE_CYC   ((`UAD_SETTLE_NS + `UAD_CLK_NS - 1) / `UAD_CLK_NS)
`endif

// File: hw/uad_pkg.sv
package uad_pkg;
    typedef enum logic [1:0] {
        UAD_DETACHED,
        UAD_SETTLE,
        UAD_ATTACHED
    } uad_state_e;
    typedef logic [3:0] uad_sel_t;
endpackage : uad_pkg

// File: hw/uad_sync_if.sv
`timescale 1ns/1ps
interface uad_sync_if;
    logic detach_req;
    logic bus_sense;
    modport src (output detach_req, output bus_sense);
    modport dst (input  detach_req, input  bus_sense);
endinterface : uad_sync_if

// File: hw/uad_sync.sv
`timescale 1ns/1ps
module uad_sync (
    input  wire logic core_clk_i,  // Clock
    input  wire logic rst_b_i,     // Sync reset, low
    input  wire logic detach_i,    // Raw detach request
    input  wire logic sense_i,     // Raw bus sense
    uad_sync_if.src   sync_o       // Synchronised levels
);
    logic [1:0] det_r, det_nxt;
    logic [1:0] sen_r, sen_nxt;
    always_comb begin
        det_nxt = {det_r[0], detach_i};
        sen_nxt = {sen_r[0], sense_i};
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            det_r <= 2'h3;
            sen_r <= 2'h0;
        end else begin
            det_r <= det_nxt;
            sen_r <= sen_nxt;
        end
    end
    assign sync_o.detach_req = det_r[1];
    assign sync_o.bus_sense  = sen_r[1];
endmodule : uad_sync

// File: hw/uad_top.sv
`timescale 1ns/1ps
`include "uad_params.svh"
module uad_top import uad_pkg::*; #(
    parameter int GPIO_W     = `UAD_GPIO_W,
    parameter int SETTLE_CYC = `UAD_SETTLE_CYC
) (
    input  wire logic              core_clk_i,        // 125 MHz clock
    input  wire logic              rst_b_i,           // Sync reset, low
    input  wire logic              ready_i,           // Stack ready to enumerate
    input  wire logic              self_powered_i,    // Self-powered mode
    input  wire logic              ext_pullup_i,      // Use external pull-up line
    input  wire logic [3:0]        sense_sel_i,       // Sense line select
    input  wire logic              sense_sel_en_i,    // Override default sense line
    input  wire logic [3:0]        detach_sel_i,      // Detach line select
    input  wire logic [3:0]        wake_sel_i,        // Wake line select
    input  wire logic [3:0]        pullup_sel_i,      // External pull-up line select
    input  wire logic              wake_req_i,        // Request host wake
    input  wire logic              inband_wake_req_i, // Request in-band resume
    input  wire logic              phy_dp_o_i,        // Transceiver D+ drive
    input  wire logic              phy_dm_o_i,        // Transceiver D- drive
    input  wire logic              phy_oe_i,          // Transceiver drive enable
    input  wire logic [GPIO_W-1:0] general_purpose_line_i,  // Pin levels
    output logic [GPIO_W-1:0]      general_purpose_line_o,  // Pin drive values
    output logic [GPIO_W-1:0]      general_purpose_line_oe_o, // Pin enables
    output logic                   d_plus_line_o,     // D+ drive value
    output logic                   d_plus_line_oe_o,  // D+ enable
    output logic                   d_minus_line_o,    // D- drive value
    output logic                   d_minus_line_oe_o, // D- enable
    output logic                   int_pullup_o,      // Internal pull-up on
    output logic                   inband_wake_o,     // In-band resume allowed
    output logic                   attached_o,        // Connected and settled
    output logic                   full_speed_o       // Full-speed signalling
);
    // Selects are four bits wide and the default lines reach line 5; the settle counter is 16 bits
    if (GPIO_W < 6 || GPIO_W > 16 || SETTLE_CYC < 1 || SETTLE_CYC > 65536) begin : g_bad_params
        $error("uad_top: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin selection

    // Selects beyond the pin count read as low and drive nothing
    function automatic logic line_ok(input logic [3:0] s);
        line_ok = int'(s) < GPIO_W;
    endfunction : line_ok

    function automatic logic pick(input logic [GPIO_W-1:0] v, input logic [3:0] s);
        pick = line_ok(s) ? v[s] : 1'b0;
    endfunction : pick

    logic sense_raw, detach_raw;
    always_comb begin
        sense_raw  = pick(general_purpose_line_i,
                          sense_sel_en_i ? sense_sel_i : 4'(`UAD_SENSE_LINE));
        detach_raw = pick(general_purpose_line_i, detach_sel_i);
    end

    // Both raw inputs pass two flip-flops before any decision uses them
    uad_sync_if s_if ();
    uad_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .detach_i   (detach_raw),
        .sense_i    (sense_raw),
        .sync_o     (s_if.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // Connection state

    // Pull-up is on during SETTLE; attached only after SETTLE_CYC steady cycles
    uad_state_e st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic        conn_ok;
    always_comb begin
        // Bus-powered mode runs from the bus itself, so the sense line is not consulted
        conn_ok = ready_i && !s_if.detach_req && (!self_powered_i || s_if.bus_sense);
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            UAD_DETACHED: begin
                cnt_nxt = 16'h0000;
                if (conn_ok)
                    st_nxt = UAD_SETTLE;
            end
            UAD_SETTLE: begin
                if (!conn_ok)
                    st_nxt = UAD_DETACHED;
                else if (int'(cnt_r) >= SETTLE_CYC - 1)
                    st_nxt = UAD_ATTACHED;
                else
                    cnt_nxt = cnt_r + 16'h0001;
            end
            UAD_ATTACHED: begin
                if (!conn_ok)
                    st_nxt = UAD_DETACHED;
            end
        endcase
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_r  <= UAD_DETACHED;
            cnt_r <= 16'h0000;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers

    logic [GPIO_W-1:0] gpo_nxt, gpoe_nxt;
    logic dp_nxt, dpoe_nxt, dm_nxt, dmoe_nxt, ipu_nxt, ibw_nxt, att_nxt, wake_nxt, pu_on;
    always_comb begin
        pu_on    = conn_ok && (st_r != UAD_DETACHED);
        ipu_nxt  = pu_on && !ext_pullup_i;
        dpoe_nxt = conn_ok && phy_oe_i;
        dmoe_nxt = conn_ok && phy_oe_i;
        // Transceiver levels pass through; only the enables are gated
        dp_nxt   = phy_dp_o_i;
        dm_nxt   = phy_dm_o_i;
        ibw_nxt  = inband_wake_req_i && conn_ok && (st_r == UAD_ATTACHED);
        att_nxt  = conn_ok && (st_r == UAD_ATTACHED);
        wake_nxt = wake_req_i && s_if.detach_req;
        gpo_nxt  = '0;
        gpoe_nxt = '0;
        // Wake line is always driven, unless the external pull-up uses the same line, so the host never sees it float
        if (line_ok(wake_sel_i)) begin
            gpo_nxt[wake_sel_i]  = wake_nxt;
            gpoe_nxt[wake_sel_i] = 1'b1;
        end
        // External pull-up line floats while off, so the resistor is truly disconnected
        if (ext_pullup_i && line_ok(pullup_sel_i)) begin
            gpo_nxt[pullup_sel_i]  = pu_on;
            gpoe_nxt[pullup_sel_i] = pu_on;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            general_purpose_line_o    <= '0;
            general_purpose_line_oe_o <= '0;
            d_plus_line_o             <= 1'b0;
            d_plus_line_oe_o          <= 1'b0;
            d_minus_line_o            <= 1'b0;
            d_minus_line_oe_o         <= 1'b0;
            int_pullup_o              <= 1'b0;
            inband_wake_o             <= 1'b0;
            attached_o                <= 1'b0;
            full_speed_o              <= 1'b0;
        end else begin
            general_purpose_line_o    <= gpo_nxt;
            general_purpose_line_oe_o <= gpoe_nxt;
            d_plus_line_o             <= dp_nxt;
            d_plus_line_oe_o          <= dpoe_nxt;
            d_minus_line_o            <= dm_nxt;
            d_minus_line_oe_o         <= dmoe_nxt;
            int_pullup_o              <= ipu_nxt;
            inband_wake_o             <= ibw_nxt;
            attached_o                <= att_nxt;
            full_speed_o              <= att_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Checks with |=> look one edge after their condition, those with |-> in the same cycle; out of reset only
    a_detach_kills_pullup: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_if.detach_req |=> !int_pullup_o && !d_plus_line_oe_o && !d_minus_line_oe_o)
        else $error("pull-up or drive while detached");
    a_sense_gates_pullup: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (self_powered_i && !s_if.bus_sense) |=> !int_pullup_o)
        else $error("pull-up on without bus supply");
    a_ready_gates_pullup: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !ready_i |=> !int_pullup_o && !attached_o)
        else $error("pull-up before ready");
    a_ext_no_internal: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ext_pullup_i |=> !int_pullup_o)
        else $error("internal pull-up with external selected");
    a_wake_only_detach: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (!s_if.detach_req && int'(wake_sel_i) < GPIO_W) |=> !general_purpose_line_o[$past(wake_sel_i)])
        else $error("wake outside detach");
    a_no_inband_detach: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_if.detach_req |=> !inband_wake_o)
        else $error("in-band wake while detached");
    a_reattach_pullup: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (st_r == UAD_DETACHED && conn_ok && !ext_pullup_i) ##1 (conn_ok && !ext_pullup_i) |=> int_pullup_o)
        else $error("no pull-up after reattach");
    a_settle_attach: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(attached_o) |-> $past(st_r == UAD_ATTACHED) && $past(st_r == UAD_SETTLE, 2) && full_speed_o)
        else $error("attached without settling");
    a_sense_default: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !sense_sel_en_i |-> sense_raw == general_purpose_line_i[`UAD_SENSE_LINE])
        else $error("wrong default sense line");
    a_wake_on_request: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (s_if.detach_req && wake_req_i && line_ok(wake_sel_i) && !(ext_pullup_i && pullup_sel_i == wake_sel_i))
        |=> general_purpose_line_o[$past(wake_sel_i)] && general_purpose_line_oe_o[$past(wake_sel_i)])
        else $error("wake request not driven");
    a_ext_pullup_off: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (s_if.detach_req && ext_pullup_i && line_ok(pullup_sel_i))
        |=> !general_purpose_line_o[$past(pullup_sel_i)] && !general_purpose_line_oe_o[$past(pullup_sel_i)])
        else $error("external pull-up on while detached");
    a_detach_sync_lag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $changed(s_if.detach_req) |-> s_if.detach_req == $past(detach_raw, 2))
        else $error("detach not two stages behind pin");
    a_oe_follows_phy: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (conn_ok && phy_oe_i) |=> d_plus_line_oe_o && d_minus_line_oe_o)
        else $error("data lines not driven while connected");
endmodule : uad_top

// File: verif/uad_host_model.sv
`timescale 1ns/1ps
module uad_host_model (
    input  wire logic core_clk_i,       // Clock
    input  wire logic dp_drv_i,         // D+ drive value
    input  wire logic dp_oe_i,          // D+ enable
    input  wire logic int_pullup_i,     // Internal pull-up on
    input  wire logic ext_pullup_i,     // External pull-up pin high
    output logic      dp_level_o,       // Resolved D+ level
    output logic      fs_seen_o         // Host sees a full-speed device
);
    // Host holds a pull-down, so D+ only idles high through a pull-up
    always_comb begin
        if (dp_oe_i) begin
            dp_level_o = dp_drv_i;
        end else begin
            dp_level_o = int_pullup_i | ext_pullup_i;
        end
    end
    always_ff @(posedge core_clk_i) begin
        fs_seen_o <= int_pullup_i | ext_pullup_i;
    end
endmodule : uad_host_model

// File: verif/tb_usb_attach_detach_control.sv
`timescale 1ns/1ps
module tb_usb_attach_detach_control;
    logic        clk, rst_b, ready, self_pw, ext_pu, sen_en, wake, ibw;
    logic [3:0]  sen_sel, det_sel, wk_sel, pu_sel;
    logic [15:0] pins, gpo, gpoe, gpi;
    logic        dpo, dpoe, dmo, dmoe, ipu, ibo, att, fs, dp_lvl, fs_seen;
    logic        phy_dp, phy_dm, phy_oe;
    int          failures, checks_done;
    // Driven pins read back their own value, others the bench level
    assign gpi = (gpo & gpoe) | (pins & ~gpoe);
    uad_top #(.GPIO_W(16), .SETTLE_CYC(2)) uad_top_i (
        .core_clk_i(clk), .rst_b_i(rst_b), .ready_i(ready), .self_powered_i(self_pw),
        .ext_pullup_i(ext_pu), .sense_sel_i(sen_sel), .sense_sel_en_i(sen_en),
        .detach_sel_i(det_sel), .wake_sel_i(wk_sel), .pullup_sel_i(pu_sel),
        .wake_req_i(wake), .inband_wake_req_i(ibw), .phy_dp_o_i(phy_dp), .phy_dm_o_i(phy_dm),
        .phy_oe_i(phy_oe), .general_purpose_line_i(gpi), .general_purpose_line_o(gpo),
        .general_purpose_line_oe_o(gpoe), .d_plus_line_o(dpo), .d_plus_line_oe_o(dpoe),
        .d_minus_line_o(dmo), .d_minus_line_oe_o(dmoe), .int_pullup_o(ipu),
        .inband_wake_o(ibo), .attached_o(att), .full_speed_o(fs));
    uad_host_model uad_host_model_i (
        .core_clk_i(clk), .dp_drv_i(dpo), .dp_oe_i(dpoe), .int_pullup_i(ipu),
        .ext_pullup_i(gpo[pu_sel] & gpoe[pu_sel]), .dp_level_o(dp_lvl), .fs_seen_o(fs_seen));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Long enough for sync, settle and output register stages
    task automatic settle;
        repeat (10) @(posedge clk);
    endtask : settle
    task automatic t_attach;
        settle;
        chk(ipu, 1'b0);
        ready <= 1'b1;
        settle;
        chk(ipu, 1'b1);
        chk(att, 1'b1);
        chk(fs, 1'b1);
        chk(fs_seen, 1'b1);
        chk(dpoe, 1'b1);
        chk(dmoe, 1'b1);
        chk(dpo, 1'b1);
        chk(dmo, 1'b0);
        phy_oe <= 1'b0;
        phy_dp <= 1'b0;
        phy_dm <= 1'b1;
        settle;
        chk(dpoe, 1'b0);
        chk(dpo, 1'b0);
        chk(dmo, 1'b1);
        chk(dp_lvl, 1'b1);
        phy_oe <= 1'b1;
        phy_dp <= 1'b1;
        phy_dm <= 1'b0;
    endtask : t_attach
    task automatic t_sense;
        self_pw <= 1'b1;
        settle;
        chk(ipu, 1'b0);
        pins[2] <= 1'b1;
        settle;
        chk(ipu, 1'b1);
        sen_en  <= 1'b1;
        sen_sel <= 4'h7;
        settle;
        chk(ipu, 1'b0);
        pins[7] <= 1'b1;
        settle;
        chk(ipu, 1'b1);
        self_pw <= 1'b0;
    endtask : t_sense
    task automatic t_detach;
        wake <= 1'b1;
        ibw  <= 1'b1;
        settle;
        chk(ibo, 1'b1);
        chk(gpo[4], 1'b0);
        pins[3] <= 1'b1;
        settle;
        chk(dpoe, 1'b0);
        chk(dmoe, 1'b0);
        chk(ipu, 1'b0);
        chk(fs_seen, 1'b0);
        chk(dp_lvl, 1'b0);
        chk(gpo[4], 1'b1);
        chk(gpoe[4], 1'b1);
        chk(ibo, 1'b0);
        wake    <= 1'b0;
        pins[3] <= 1'b0;
        settle;
        chk(ipu, 1'b1);
        chk(att, 1'b1);
    endtask : t_detach
    task automatic t_extpu;
        ext_pu <= 1'b1;
        pu_sel <= 4'h9;
        settle;
        chk(ipu, 1'b0);
        chk(gpo[9], 1'b1);
        chk(gpoe[9], 1'b1);
        chk(fs_seen, 1'b1);
    endtask : t_extpu
    task automatic t_remap;
        det_sel  <= 4'hC;
        wk_sel   <= 4'hB;
        pins[12] <= 1'b1;
        wake     <= 1'b1;
        settle;
        chk(gpo[9], 1'b0);
        chk(fs_seen, 1'b0);
        chk(gpo[11], 1'b1);
        chk(gpoe[11], 1'b1);
        chk(gpoe[4], 1'b0);
        pins[12] <= 1'b0;
        wake     <= 1'b0;
        settle;
        chk(gpo[11], 1'b0);
        chk(gpo[9], 1'b1);
    endtask : t_remap
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, ready, self_pw, ext_pu, sen_en, wake, ibw} = '0;
        {phy_dp, phy_dm, phy_oe} = 3'h5;
        // Select parked off line 2 so only the default mapping can find the sense level
        {sen_sel, det_sel, wk_sel, pu_sel} = {4'hA, 4'h3, 4'h4, 4'h5};
        pins = 16'h0000;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_attach;
        t_sense;
        t_detach;
        t_extpu;
        t_remap;
        close_out;
    end
    // The run needs under 200 cycles; this allows about 25 times that
    initial begin
        #40000;
        failures++;
        close_out;
    end
endmodule : tb_usb_attach_detach_control
